// File: verilog/alarm_flags_pkg.sv
// Constants, register map and types for the alarm and supply-fail flag block.
// Assumes a 250 MHz core clock and a 32-bit APB register bus.
package alarm_flags_pkg;

    // Clock and timing
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned ADDR_HOLD_NS = 50;
    localparam int unsigned HOLD_CYCLES = (ADDR_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned WARN_NS = 10000;
    localparam int unsigned WARN_CYCLES = (WARN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SYNC_STAGES = 2;

    localparam int unsigned HOLD_W = 5;
    localparam int unsigned WARN_W = 12;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYCLES - 1);
    localparam logic [WARN_W-1:0] WARN_LAST = WARN_W'(WARN_CYCLES - 1);
    localparam logic [1:0] SYNC_LAST = 2'(SYNC_STAGES);

    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_ALM_SEC = 4'h1;
    localparam logic [3:0] IDX_ALM_MIN = 4'h3;
    localparam logic [3:0] IDX_ALM_HOUR = 4'h5;
    localparam logic [3:0] IDX_ALM_DATE = 4'h7;
    localparam logic [3:0] IDX_IRQ_EN = 4'hC;
    localparam logic [3:0] IDX_FLAGS = 4'hD;
    localparam logic [3:0] IDX_STATUS = 4'hE;

    // Alarm byte mask field
    localparam int unsigned MASK_HI_BIT = 7;
    localparam int unsigned MASK_LO_BIT = 6;
    localparam logic [7:0] ALARM_RESET = 8'h00;

    // Enable register fields
    localparam int unsigned EN_ALARM_BIT = 0;
    localparam int unsigned EN_SUPPLY_BIT = 1;
    localparam logic [1:0] EN_RESET = 2'h0;

    // Flags register fields
    localparam int unsigned FLAG_ALARM_BIT = 0;
    localparam int unsigned FLAG_SUPPLY_BIT = 1;
    localparam int unsigned FLAG_BATT_BIT = 2;

    // Status register fields
    localparam int unsigned ST_SUPPLY_LOW_BIT = 0;
    localparam int unsigned ST_WARN_BIT = 1;
    localparam int unsigned ST_RESET_BIT = 2;

    typedef enum logic [1:0] {
        supply_normal,
        supply_warn,
        supply_reset
    } supply_state_t;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [3:0] idx);
        byte_addr = {{(ADDR_W-6){1'b0}}, idx, 2'b00};
    endfunction : byte_addr

    function automatic logic byte_masked(input logic [7:0] b);
        byte_masked = b[MASK_HI_BIT] & b[MASK_LO_BIT];
    endfunction : byte_masked

endpackage : alarm_flags_pkg

// File: verilog/alarm_compare.sv
// Masked compare of the four alarm bytes against the running clock bytes.
// Assumes clock bytes come from same-clock counter logic, BCD coded.
`timescale 1ns/1ps
`default_nettype none
module alarm_compare
    import alarm_flags_pkg::*;
(
    input wire logic [7:0] alm_sec,
    input wire logic [7:0] alm_min,
    input wire logic [7:0] alm_hour,
    input wire logic [7:0] alm_date,
    input wire logic [7:0] now_sec,
    input wire logic [7:0] now_min,
    input wire logic [7:0] now_hour,
    input wire logic [7:0] now_date,
    output logic match
);
    logic sec_ok;
    logic min_ok;
    logic hour_ok;
    logic date_ok;

    // Full byte compared; BCD never uses both top bits, so no clash
    assign sec_ok = byte_masked(alm_sec) | (alm_sec == now_sec); // [RULE_10]
    assign min_ok = byte_masked(alm_min) | (alm_min == now_min); // [RULE_10]
    assign hour_ok = byte_masked(alm_hour) | (alm_hour == now_hour); // [RULE_10]
    assign date_ok = byte_masked(alm_date) | (alm_date == now_date); // [RULE_10]

    // All masked: every update; none masked: date-level match
    assign match = sec_ok & min_ok & hour_ok & date_ok; // [RULE_01]

endmodule : alarm_compare
`default_nettype wire

// File: verilog/alarm_mask_powerfail_flags.sv
// Alarm masking, supply-fail flag and warning, battery check, APB registers.
// Assumes clock bytes and update strobe from same-clock logic; supply_low
// and battery_low arrive from analog comparators outside this clock domain.
//
// How it works
// [RULE_01] All four bytes masked: alarm fires on every update, each second.
// [RULE_02] Only seconds unmasked: alarm fires when seconds match, once a minute.
// [RULE_03] Seconds and minutes unmasked: alarm fires hourly on both matching.
// [RULE_04] Only date masked: alarm fires daily on hours, minutes, seconds.
// [RULE_05] Nothing masked: alarm fires when date and time all match.
// [RULE_06] Supply dropping to the threshold sets the supply-fail flag.
// [RULE_07] Supply-fail flag with its enable set pulls the interrupt low.
// [RULE_08] Interrupt comes a warning interval before processor reset and deselect.
// [RULE_09] Power-up battery check clears battery-ok flag when battery is low.
// [RULE_10] Both top bits of an alarm byte set exclude that byte.
// [RULE_11] Each update compares bytes; full match sets alarm flag, may interrupt.
// [RULE_12] Flags read clears flags, releases interrupt; address held 50 ns first.
// [RULE_13] Software uses only the five listed mask patterns.
// [RULE_14] Supply-fail flag stays set until the flags register is read.
`timescale 1ns/1ps
`default_nettype none
module alarm_mask_powerfail_flags
    import alarm_flags_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] now_sec,
    input wire logic [7:0] now_min,
    input wire logic [7:0] now_hour,
    input wire logic [7:0] now_date,
    input wire logic update_tick,
    input wire logic supply_low,
    input wire logic battery_low,
    output logic irq_out,
    output logic irq_oe_b,
    output logic cpu_reset_b,
    output logic mem_deselect
);
    logic [7:0] alm_sec_q;
    logic [7:0] alm_min_q;
    logic [7:0] alm_hour_q;
    logic [7:0] alm_date_q;
    logic [1:0] irq_en_q;
    logic alarm_flag_q;
    logic supply_fail_flag_q;
    logic battery_ok_flag_q;
    logic alarm_match;

    logic supply_meta_q;
    logic supply_low_q;
    logic battery_meta_q;
    logic battery_low_q;
    logic [1:0] batt_wait_q;
    logic batt_checked_q;

    supply_state_t supply_state_q;
    supply_state_t supply_state_d;
    logic [WARN_W-1:0] warn_cnt_q;
    logic supply_low_prev_q;
    logic supply_fall;

    logic [HOLD_W-1:0] hold_cnt_q;
    logic [ADDR_W-1:0] hold_addr_q;
    logic ack_q;
    logic err_q;
    logic [DATA_W-1:0] rdata_q;
    logic access;
    logic done;
    logic sel_flags;
    logic addr_ok;
    logic ready_now;
    logic [DATA_W-1:0] rd_mux;
    logic flags_read;
    logic irq_active;

    alarm_compare u_compare (
        .alm_sec(alm_sec_q),
        .alm_min(alm_min_q),
        .alm_hour(alm_hour_q),
        .alm_date(alm_date_q),
        .now_sec(now_sec),
        .now_min(now_min),
        .now_hour(now_hour),
        .now_date(now_date),
        .match(alarm_match)
    );

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            supply_meta_q <= 1'b0;
            supply_low_q <= 1'b0;
            battery_meta_q <= 1'b0;
            battery_low_q <= 1'b0;
        end else if (clk_en) begin
            supply_meta_q <= supply_low;
            supply_low_q <= supply_meta_q;
            battery_meta_q <= battery_low;
            battery_low_q <= battery_meta_q;
        end
    end

    // APB decode
    assign access = psel & penable;
    assign done = access & ack_q;
    assign sel_flags = (paddr == byte_addr(IDX_FLAGS));

    always_comb begin
        addr_ok = 1'b1;
        rd_mux = '0;
        unique case (paddr)
            byte_addr(IDX_ALM_SEC): rd_mux[7:0] = alm_sec_q;
            byte_addr(IDX_ALM_MIN): rd_mux[7:0] = alm_min_q;
            byte_addr(IDX_ALM_HOUR): rd_mux[7:0] = alm_hour_q;
            byte_addr(IDX_ALM_DATE): rd_mux[7:0] = alm_date_q;
            byte_addr(IDX_IRQ_EN): rd_mux[1:0] = irq_en_q;
            byte_addr(IDX_FLAGS): begin
                rd_mux[FLAG_ALARM_BIT] = alarm_flag_q;
                rd_mux[FLAG_SUPPLY_BIT] = supply_fail_flag_q;
                rd_mux[FLAG_BATT_BIT] = battery_ok_flag_q;
            end
            byte_addr(IDX_STATUS): begin
                rd_mux[ST_SUPPLY_LOW_BIT] = supply_low_q;
                rd_mux[ST_WARN_BIT] = (supply_state_q == supply_warn);
                rd_mux[ST_RESET_BIT] = (supply_state_q == supply_reset);
            end
            default: addr_ok = 1'b0;
        endcase
    end

    // Flags read waits until the address has stood long enough
    assign ready_now = !(sel_flags && !pwrite) || (hold_cnt_q >= HOLD_LAST); // [RULE_12]

    // Address hold counter, restarts whenever the address moves
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hold_cnt_q <= '0;
            hold_addr_q <= '0;
        end else if (clk_en) begin
            hold_addr_q <= paddr;
            if (!psel || done || (paddr != hold_addr_q)) begin
                hold_cnt_q <= '0;
            end else if (hold_cnt_q != HOLD_LAST) begin
                hold_cnt_q <= hold_cnt_q + 1'b1; // [RULE_12]
            end
        end
    end

    // Answer registered: one wait state, more for a flags read
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= '0;
        end else if (clk_en) begin
            if (done) begin
                ack_q <= 1'b0;
                err_q <= 1'b0;
            end else if (access && ready_now) begin
                ack_q <= 1'b1;
                err_q <= !addr_ok;
                rdata_q <= pwrite ? '0 : rd_mux;
            end
        end
    end

    assign pready = ack_q & access;
    assign pslverr = err_q & access;
    assign prdata = rdata_q;

    // Software-written alarm and enable registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            alm_sec_q <= ALARM_RESET;
            alm_min_q <= ALARM_RESET;
            alm_hour_q <= ALARM_RESET;
            alm_date_q <= ALARM_RESET;
            irq_en_q <= EN_RESET;
        end else if (clk_en && done && pwrite && pstrb[0]) begin
            unique case (paddr)
                byte_addr(IDX_ALM_SEC): alm_sec_q <= pwdata[7:0];
                byte_addr(IDX_ALM_MIN): alm_min_q <= pwdata[7:0];
                byte_addr(IDX_ALM_HOUR): alm_hour_q <= pwdata[7:0];
                byte_addr(IDX_ALM_DATE): alm_date_q <= pwdata[7:0];
                byte_addr(IDX_IRQ_EN): irq_en_q <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    assign flags_read = done && !pwrite && sel_flags; // [RULE_12]

    // Alarm flag; a new match beats the clearing read
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            alarm_flag_q <= 1'b0;
        end else if (clk_en) begin
            if (update_tick && alarm_match) begin
                alarm_flag_q <= 1'b1; // [RULE_11] [RULE_02] [RULE_03] [RULE_04] [RULE_05]
            end else if (flags_read) begin
                alarm_flag_q <= 1'b0; // [RULE_12]
            end
        end
    end

    assign supply_fall = supply_low_q & !supply_low_prev_q;

    // Supply-fail flag is sticky; recovery alone never clears it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            supply_fail_flag_q <= 1'b0;
            supply_low_prev_q <= 1'b0;
        end else if (clk_en) begin
            supply_low_prev_q <= supply_low_q;
            if (supply_fall) begin
                supply_fail_flag_q <= 1'b1; // [RULE_06]
            end else if (flags_read) begin
                supply_fail_flag_q <= 1'b0; // [RULE_14] [RULE_12]
            end
        end
    end

    // Battery sampled once, after the synchroniser has filled
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            batt_wait_q <= '0;
            batt_checked_q <= 1'b0;
            battery_ok_flag_q <= 1'b0;
        end else if (clk_en && !batt_checked_q) begin
            if (batt_wait_q == SYNC_LAST) begin
                batt_checked_q <= 1'b1;
                battery_ok_flag_q <= !battery_low_q; // [RULE_09]
            end else begin
                batt_wait_q <= batt_wait_q + 1'b1;
            end
        end
    end

    // Warning interval, then processor reset and deselect
    always_comb begin
        supply_state_d = supply_state_q;
        unique case (supply_state_q)
            supply_normal: begin
                if (supply_low_q) begin
                    supply_state_d = supply_warn;
                end
            end
            supply_warn: begin
                if (!supply_low_q) begin
                    supply_state_d = supply_normal;
                end else if (warn_cnt_q == WARN_LAST) begin
                    supply_state_d = supply_reset; // [RULE_08]
                end
            end
            supply_reset: begin
                if (!supply_low_q) begin
                    supply_state_d = supply_normal;
                end
            end
            default: supply_state_d = supply_normal;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            supply_state_q <= supply_normal;
            warn_cnt_q <= '0;
        end else if (clk_en) begin
            supply_state_q <= supply_state_d;
            if (supply_state_q == supply_warn) begin
                warn_cnt_q <= warn_cnt_q + 1'b1; // [RULE_08]
            end else begin
                warn_cnt_q <= '0;
            end
        end
    end

    assign cpu_reset_b = (supply_state_q != supply_reset); // [RULE_08]
    assign mem_deselect = (supply_state_q == supply_reset); // [RULE_08]

    // Open-drain interrupt: pulled low only, released after flags read
    assign irq_active = (alarm_flag_q & irq_en_q[EN_ALARM_BIT]) // [RULE_11]
        | (supply_fail_flag_q & irq_en_q[EN_SUPPLY_BIT]); // [RULE_07]
    assign irq_out = 1'b0;
    assign irq_oe_b = !irq_active; // [RULE_07]

endmodule : alarm_mask_powerfail_flags
`default_nettype wire

// File: verif/apb_host.sv
// APB master standing in for the host processor.
// Assumes one clock; the bench calls xfer hierarchically.
`timescale 1ns/1ps
`default_nettype none
module apb_host
    import alarm_flags_pkg::*;
(
    input wire logic clk,
    output logic [ADDR_W-1:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [DATA_W-1:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        {paddr, psel, penable, pwrite, pwdata} = '0;
        pstrb = 4'hF;
    end
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] r,
        output logic e);
        logic rdy;
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Answer taken at the very edge that completes the transfer
        do begin
            @(posedge clk);
            rdy = pready;
        end while (rdy !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show the inverse, not the last value
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
    task automatic set_strb(input logic [3:0] s);
        pstrb <= s;
    endtask : set_strb
endmodule : apb_host
`default_nettype wire

// File: verif/flags_sva.sv
// Checker on the APB and supervisor pins of the flag block.
// Assumes one clock domain; bound to the block below.
`timescale 1ns/1ps
`default_nettype none
module flags_sva
    import alarm_flags_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic supply_low,
    input wire logic irq_oe_b,
    input wire logic cpu_reset_b,
    input wire logic mem_deselect
);
    localparam logic [ADDR_W-1:0] FLAGS_A = ADDR_W'(IDX_FLAGS) << 2;
    localparam logic [ADDR_W-1:0] EN_A = ADDR_W'(IDX_IRQ_EN) << 2;
    logic [11:0] low_q;
    logic rd_flags;
    logic [4:0] rd_run_q;
    assign rd_flags = psel && !pwrite && paddr == FLAGS_A;
    // Cycles the flags address has stood selected, saturating
    always_ff @(posedge clk) begin
        if (!rst_b || !rd_flags) begin
            rd_run_q <= '0;
        end else if (rd_run_q != 5'h1F) begin
            rd_run_q <= rd_run_q + 5'h01;
        end
    end
    // Raw pin time below threshold, saturating
    always_ff @(posedge clk) begin
        if (!rst_b || !supply_low) begin
            low_q <= '0;
        end else if (low_q != 12'hFFF) begin
            low_q <= low_q + 12'h001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_flags_addr_held: assert property (pready && rd_flags |->
        rd_run_q >= HOLD_CYCLES)
        else $error("flags read answered too early");
    a_reg_ready_next: assert property (psel && penable && !$past(penable)
        && !rd_flags |=> pready)
        else $error("register access slow");
    a_irq_release_cause: assert property ($rose(irq_oe_b) |->
        $past(pready && (rd_flags || pwrite && paddr == EN_A)))
        else $error("interrupt released without cause");
    a_warn_interval: assert property ($rose(mem_deselect) |->
        low_q >= WARN_CYCLES)
        else $error("deselect before warning interval");
    a_reset_deselect: assert property (
        cpu_reset_b != mem_deselect)
        else $error("reset and deselect disagree");
    a_reset_needs_fail: assert property ($fell(cpu_reset_b) |->
        supply_low)
        else $error("processor reset without supply fail");
endmodule : flags_sva
bind alarm_mask_powerfail_flags flags_sva chk_u (.clk(clk), .rst_b(rst_b),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .supply_low(supply_low),
    .irq_oe_b(irq_oe_b), .cpu_reset_b(cpu_reset_b),
    .mem_deselect(mem_deselect));
`default_nettype wire

// File: verif/alarm_mask_powerfail_flags_tb.sv
// Self-checking bench for the alarm and supply-fail flag block.
// Assumes host model and bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module alarm_mask_powerfail_flags_tb
    import alarm_flags_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic update_tick = 1'b0;
    logic supply_low = 1'b0;
    logic battery_low = 1'b0;
    logic [7:0] nv [4] = '{default: 8'h00};
    logic [ADDR_W-1:0] paddr;
    logic psel, penable, pwrite, pready, pslverr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic irq_out, irq_oe_b, cpu_reset_b, mem_deselect;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    initial begin
        forever #2 clk = ~clk;
    end
    alarm_mask_powerfail_flags dut_u (.clk(clk), .rst_b(rst_b),
        .clk_en(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .now_sec(nv[0]),
        .now_min(nv[1]), .now_hour(nv[2]), .now_date(nv[3]),
        .update_tick(update_tick), .supply_low(supply_low),
        .battery_low(battery_low), .irq_out(irq_out), .irq_oe_b(irq_oe_b),
        .cpu_reset_b(cpu_reset_b), .mem_deselect(mem_deselect));
    apb_host host_u (.clk(clk), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task automatic complete_run();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [DATA_W-1:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_bit(input logic got, exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit
    // Read data is judged only when no error is expected
    task automatic op(input logic w, input logic [3:0] i,
        input logic [DATA_W-1:0] d, input logic ee);
        logic [DATA_W-1:0] r;
        logic e;
        host_u.xfer(w, ADDR_W'(i) << 2, d, r, e);
        if (!w && !ee) chk(r, d);
        chk_bit(e, ee);
    endtask : op
    task automatic do_reset(input logic bl);
        battery_low <= bl;
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge clk);
    endtask : do_reset
    // Ends on an edge; the interrupt has been settled for two cycles
    task automatic pulse();
        @(posedge clk);
        update_tick <= 1'b1;
        @(posedge clk);
        update_tick <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : pulse
    task automatic t_regs();
        do_reset(1'b1);
        op(1'b0, IDX_FLAGS, 32'h0, 1'b0);
        do_reset(1'b0);
        op(1'b0, IDX_FLAGS, 32'h4, 1'b0);
        op(1'b0, IDX_ALM_DATE, 32'h0, 1'b0);
        op(1'b0, IDX_IRQ_EN, 32'h0, 1'b0);
        host_u.set_strb(4'h0);
        op(1'b1, IDX_ALM_SEC, 32'h33, 1'b0);
        host_u.set_strb(4'hF);
        op(1'b0, IDX_ALM_SEC, 32'h0, 1'b0);
        op(1'b1, IDX_ALM_SEC, 32'hFFFF_FF33, 1'b0);
        op(1'b0, IDX_ALM_SEC, 32'h33, 1'b0);
        op(1'b1, IDX_FLAGS, 32'h3, 1'b0);
        op(1'b0, IDX_FLAGS, 32'h4, 1'b0);
        op(1'b0, 4'hF, 32'h0, 1'b1);
    endtask : t_regs
    task automatic t_alarm();
        logic [7:0] v [4] = '{8'h25, 8'h37, 8'h12, 8'h28};
        logic [3:0] ix [4] = '{IDX_ALM_SEC, IDX_ALM_MIN, IDX_ALM_HOUR,
            IDX_ALM_DATE};
        logic [7:0] b;
        op(1'b1, IDX_IRQ_EN, 32'h1, 1'b0);
        for (int k = 0; k < 5; k++) begin
            for (int i = 0; i < 4; i++) begin
                b = (i < k) ? v[i] : 8'hC0;
                op(1'b1, ix[i], DATA_W'(b), 1'b0);
                // Newest unmasked byte starts one off, to prove it counts
                b = (i < k) ? v[i] : 8'h59;
                nv[i] <= (i == k - 1) ? b + 8'h01 : b;
            end
            if (k > 0) begin
                pulse();
                chk_bit(irq_oe_b, 1'b1);
                nv[k-1] <= v[k-1];
            end
            pulse();
            case (k)
                0: chk_bit(irq_oe_b, 1'b0);
                1: chk_bit(irq_oe_b, 1'b0);
                2: chk_bit(irq_oe_b, 1'b0);
                3: chk_bit(irq_oe_b, 1'b0);
                default: chk_bit(irq_oe_b, 1'b0);
            endcase
            op(1'b0, IDX_FLAGS, 32'h5, 1'b0);
            #1;
            chk_bit(irq_oe_b, 1'b1);
            op(1'b0, IDX_FLAGS, 32'h4, 1'b0);
        end
    endtask : t_alarm
    task automatic t_supply();
        int n = 0;
        op(1'b1, IDX_IRQ_EN, 32'h2, 1'b0);
        supply_low <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk_bit(irq_oe_b, 1'b0);
        chk_bit(irq_out, 1'b0);
        chk_bit(cpu_reset_b, 1'b1);
        while (cpu_reset_b !== 1'b0 && n < 4000) begin
            @(posedge clk);
            #1;
            n++;
        end
        // Pin edge to reset: 2 sync, 1 to warn, interval; 6 already spent
        chk(DATA_W'(n), DATA_W'(WARN_CYCLES - 3));
        chk_bit(mem_deselect, 1'b1);
        op(1'b0, IDX_STATUS, 32'h5, 1'b0);
        supply_low <= 1'b0;
        repeat (6) @(posedge clk);
        chk_bit(irq_oe_b, 1'b0);
        op(1'b0, IDX_STATUS, 32'h0, 1'b0);
        op(1'b0, IDX_FLAGS, 32'h6, 1'b0);
        op(1'b0, IDX_FLAGS, 32'h4, 1'b0);
        chk_bit(irq_oe_b, 1'b1);
    endtask : t_supply
    // Whole run needs a few thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        t_regs();
        t_alarm();
        t_supply();
        complete_run();
    end
endmodule : alarm_mask_powerfail_flags_tb
`default_nettype wire
